// file: hdl/prot_map.svh
// Constants for the password and protection command block.
// Assumes a 200 MHz system clock and a slow sampled serial clock.
`ifndef PROT_MAP_SVH
`define PROT_MAP_SVH

`define OP_WREN          8'h06
`define OP_GLOBAL_UNLOCK 8'h98
`define OP_READ_PW       8'h27
`define OP_WRITE_PW      8'h28
`define OP_PW_UNLOCK     8'h29

`define PW_RESET         64'hffff_ffff_ffff_ffff
`define SECTOR_COUNT     512

`define CLK_PERIOD_NS    5
`define GOOD_PW_US       2
`define BAD_PW_US        100
`define GOOD_PW_CYCLES   ((`GOOD_PW_US * 1000) / `CLK_PERIOD_NS)
`define BAD_PW_CYCLES    ((`BAD_PW_US * 1000) / `CLK_PERIOD_NS)

`endif

// file: hdl/prot_pkg.sv
// Types for the password and protection command block.
// Assumes prot_map.svh for all numeric constants.
`default_nettype none
package prot_pkg;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_DATA,
    PH_DONE
  } phase_t;

  typedef struct packed {
    logic       rise;
    logic       fall;
    logic       cs_active;
    logic       cs_end;
    logic       din;
  } link_ev_t;

  typedef enum logic [1:0] {
    BUSY_IDLE,
    BUSY_GOOD,
    BUSY_BAD
  } busy_t;
endpackage
`default_nettype wire

// file: hdl/pin_sync.sv
// Three-stage synchroniser with edge detection for serial link pins.
// Assumes pins are asynchronous to clk; a change counts when stages 2 and 3 agree.
`include "prot_map.svh"
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Pins
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                mosi,
  // Events
  output prot_pkg::link_ev_t       ev
);
  logic [2:0] sclk_q, sclk_d;
  logic [2:0] cs_q,   cs_d;
  logic [2:0] din_q,  din_d;
  logic       sclk_st_q, sclk_st_d;
  logic       cs_st_q,   cs_st_d;

  always_comb begin
    sclk_d    = {sclk_q[1:0], sclk};
    cs_d      = {cs_q[1:0], cs_n};
    din_d     = {din_q[1:0], mosi};
    sclk_st_d = (sclk_q[2] == sclk_q[1]) ? sclk_q[2] : sclk_st_q;
    cs_st_d   = (cs_q[2] == cs_q[1]) ? cs_q[2] : cs_st_q;
    ev.rise      = (sclk_q[2] == sclk_q[1]) && sclk_q[2] && !sclk_st_q;
    ev.fall      = (sclk_q[2] == sclk_q[1]) && !sclk_q[2] && sclk_st_q;
    ev.cs_active = !cs_st_q;
    ev.cs_end    = (cs_q[2] == cs_q[1]) && cs_q[2] && !cs_st_q;
    ev.din       = din_q[2];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q    <= 3'h0;
      cs_q      <= 3'h7;
      din_q     <= 3'h0;
      sclk_st_q <= 1'b0;
      cs_st_q   <= 1'b1;
    end else begin
      sclk_q    <= sclk_d;
      cs_q      <= cs_d;
      din_q     <= din_d;
      sclk_st_q <= sclk_st_d;
      cs_st_q   <= cs_st_d;
    end
  end
endmodule
`default_nettype wire

// file: hdl/flash_prot_cmd.sv
// Protection command decoder: global dynamic unlock, password read/write, password unlock.
// Assumes SPI mode 0/3 host; serial clock sampled by clk at 200 MHz.
`include "prot_map.svh"
`default_nettype none
module flash_prot_cmd (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Serial link
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      mosi,
  output logic                           miso,
  output logic                           miso_oe,
  // Sector protection
  input  wire logic                      solid_wr_req,
  input  wire logic [`SECTOR_COUNT-1:0]  solid_wr_val,
  output logic [`SECTOR_COUNT-1:0]       dynamic_protect_bit,
  output logic [`SECTOR_COUNT-1:0]       solid_protect_bit,
  output logic [`SECTOR_COUNT-1:0]       sector_unprotected,
  // Status
  output logic                           write_latch_flag,
  output logic                           op_in_progress_flag,
  output logic                           solid_bits_lock_flag,
  output logic [63:0]                    protection_password
);
  localparam int GOOD_CYC = `GOOD_PW_CYCLES;
  localparam int BAD_CYC  = `BAD_PW_CYCLES;

  prot_pkg::link_ev_t ev;

  pin_sync u_sync (
    .clk  (clk),
    .rstn (rstn),
    .sclk (sclk),
    .cs_n (cs_n),
    .mosi (mosi),
    .ev   (ev)
  );

  prot_pkg::phase_t ph_q, ph_d;
  prot_pkg::busy_t  busy_q, busy_d;
  logic [7:0]   op_q, op_d;
  logic [6:0]   cnt_q, cnt_d;
  logic [63:0]  sh_q, sh_d;
  logic [63:0]  pw_q, pw_d;
  logic [63:0]  rd_q, rd_d;
  logic         miso_q, miso_d;
  logic         oe_q, oe_d;
  logic         wel_q, wel_d;
  logic         lock_q, lock_d;
  logic [15:0]  tmr_q, tmr_d;
  logic [`SECTOR_COUNT-1:0] dpb_q, dpb_d;
  logic [`SECTOR_COUNT-1:0] spb_q, spb_d;
  logic         in_bit;

  always_comb begin
    ph_d   = ph_q;
    op_d   = op_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    pw_d   = pw_q;
    rd_d   = rd_q;
    miso_d = miso_q;
    oe_d   = oe_q;
    wel_d  = wel_q;
    lock_d = lock_q;
    busy_d = busy_q;
    tmr_d  = tmr_q;
    dpb_d  = dpb_q;
    spb_d  = spb_q;
    in_bit = ev.din;
    if (solid_wr_req && lock_q && busy_q == prot_pkg::BUSY_IDLE) begin
      spb_d = solid_wr_val;
    end
    unique case (busy_q)
      prot_pkg::BUSY_IDLE: begin
      end
      prot_pkg::BUSY_GOOD: begin
        if (tmr_q == 16'(GOOD_CYC - 1)) begin
          busy_d = prot_pkg::BUSY_IDLE;
          lock_d = 1'b1;
          tmr_d  = 16'h0000;
        end else begin
          tmr_d = tmr_q + 16'h0001;
        end
      end
      prot_pkg::BUSY_BAD: begin
        if (tmr_q == 16'(BAD_CYC - 1)) begin
          busy_d = prot_pkg::BUSY_IDLE;
          tmr_d  = 16'h0000;
        end else begin
          tmr_d = tmr_q + 16'h0001;
        end
      end
      default: busy_d = prot_pkg::BUSY_IDLE;
    endcase
    unique case (ph_q)
      prot_pkg::PH_IDLE: begin
        if (ev.cs_active) begin
          ph_d  = prot_pkg::PH_OPCODE;
          cnt_d = 7'h00;
        end
      end
      prot_pkg::PH_OPCODE: begin
        if (ev.rise) begin
          op_d  = {op_q[6:0], in_bit};
          cnt_d = cnt_q + 7'h01;
          if (cnt_q == 7'h07) begin
            ph_d  = prot_pkg::PH_DATA;
            cnt_d = 7'h00;
            rd_d  = pw_q;
          end
        end
      end
      prot_pkg::PH_DATA: begin
        if (op_q == `OP_READ_PW && ev.fall && cnt_q != 7'h40) begin
          miso_d = rd_q[63];
          oe_d   = 1'b1;
          rd_d   = {rd_q[62:0], 1'b0};
          cnt_d  = cnt_q + 7'h01;
        end else if (op_q != `OP_READ_PW && ev.rise && cnt_q != 7'h40) begin
          sh_d  = {sh_q[62:0], in_bit};
          cnt_d = cnt_q + 7'h01;
        end
      end
      prot_pkg::PH_DONE: begin
        ph_d = prot_pkg::PH_IDLE;
      end
      default: ph_d = prot_pkg::PH_IDLE;
    endcase
    if (ev.cs_end) begin
      ph_d = prot_pkg::PH_DONE;
      oe_d = 1'b0;
      if (ph_q == prot_pkg::PH_DATA && busy_q == prot_pkg::BUSY_IDLE) begin
        if (op_q == `OP_WREN && cnt_q == 7'h00) begin
          wel_d = 1'b1;
        end else if (op_q == `OP_GLOBAL_UNLOCK && cnt_q == 7'h00 && wel_q) begin
          dpb_d = '0;
          wel_d = 1'b0;
        end else if (op_q == `OP_WRITE_PW && cnt_q == 7'h40 && wel_q) begin
          pw_d  = sh_q;
          wel_d = 1'b0;
        end else if (op_q == `OP_PW_UNLOCK && cnt_q == 7'h40 && wel_q) begin
          wel_d = 1'b0;
          tmr_d = 16'h0000;
          if (sh_q == pw_q) begin
            busy_d = prot_pkg::BUSY_GOOD;
          end else begin
            busy_d = prot_pkg::BUSY_BAD;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_q   <= prot_pkg::PH_IDLE;
      busy_q <= prot_pkg::BUSY_IDLE;
      op_q   <= 8'h00;
      cnt_q  <= 7'h00;
      sh_q   <= 64'h0000_0000_0000_0000;
      pw_q   <= `PW_RESET;
      rd_q   <= 64'h0000_0000_0000_0000;
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
      wel_q  <= 1'b0;
      lock_q <= 1'b0;
      tmr_q  <= 16'h0000;
      dpb_q  <= '1;
      spb_q  <= '0;
    end else begin
      ph_q   <= ph_d;
      busy_q <= busy_d;
      op_q   <= op_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      pw_q   <= pw_d;
      rd_q   <= rd_d;
      miso_q <= miso_d;
      oe_q   <= oe_d;
      wel_q  <= wel_d;
      lock_q <= lock_d;
      tmr_q  <= tmr_d;
      dpb_q  <= dpb_d;
      spb_q  <= spb_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SECTOR_COUNT; g++) begin : g_sec
      assign sector_unprotected[g] = !dpb_q[g] && !spb_q[g];
    end
  endgenerate

  assign miso                 = miso_q;
  assign miso_oe              = oe_q;
  assign dynamic_protect_bit  = dpb_q;
  assign solid_protect_bit    = spb_q;
  assign write_latch_flag     = wel_q;
  assign op_in_progress_flag  = busy_q != prot_pkg::BUSY_IDLE;
  assign solid_bits_lock_flag = lock_q;
  assign protection_password  = pw_q;

  // Assertions
  sequence s_unlock_end;
    ev.cs_end && ph_q == prot_pkg::PH_DATA && busy_q == prot_pkg::BUSY_IDLE
      && op_q == `OP_PW_UNLOCK && cnt_q == 7'h40 && wel_q;
  endsequence

  AST_LOCK_RESET: assert property (@(posedge clk) $rose(rstn) |-> !lock_q)
    else $error("lock flag not clear after reset");
  AST_GLOBAL_CLR: assert property (@(posedge clk) disable iff (!rstn)
    (ev.cs_end && ph_q == prot_pkg::PH_DATA && busy_q == prot_pkg::BUSY_IDLE
     && op_q == `OP_GLOBAL_UNLOCK && cnt_q == 7'h00 && wel_q) |=> dpb_q == '0)
    else $error("global unlock did not clear dynamic bits");
  AST_WREN_NEEDED: assert property (@(posedge clk) disable iff (!rstn)
    (dpb_q != '0 && !wel_q) |=> dpb_q != '0)
    else $error("dynamic bits cleared without write latch");
  AST_BUSY_START: assert property (@(posedge clk) disable iff (!rstn)
    s_unlock_end |=> op_in_progress_flag)
    else $error("busy not raised by unlock");
  AST_GOOD_LOCK: assert property (@(posedge clk) disable iff (!rstn)
    (busy_q == prot_pkg::BUSY_GOOD && tmr_q == 16'(GOOD_CYC - 1))
      |=> lock_q && !op_in_progress_flag)
    else $error("correct password did not unlock");
  AST_BAD_NOLOCK: assert property (@(posedge clk) disable iff (!rstn)
    (busy_q == prot_pkg::BUSY_BAD && !lock_q) |=> !lock_q)
    else $error("wrong password set lock flag");
  AST_BAD_TIME: assert property (@(posedge clk) disable iff (!rstn)
    (busy_q == prot_pkg::BUSY_BAD && tmr_q < 16'(BAD_CYC - 1)) |=> op_in_progress_flag)
    else $error("busy dropped early after wrong password");
  AST_SPB_LOCKED: assert property (@(posedge clk) disable iff (!rstn)
    !lock_q |=> $stable(spb_q))
    else $error("solid bits changed while locked");
  AST_UNPROT: assert property (@(posedge clk) disable iff (!rstn)
    sector_unprotected == ~(dpb_q | spb_q))
    else $error("unprotected map wrong");
  AST_READ_MSB: assert property (@(posedge clk) disable iff (!rstn)
    (ph_q == prot_pkg::PH_DATA && op_q == `OP_READ_PW && ev.fall && cnt_q == 7'h00)
      |=> miso == pw_q[63] && miso_oe)
    else $error("password read does not start with MSB");
  AST_PW_STORE: assert property (@(posedge clk) disable iff (!rstn)
    (ev.cs_end && ph_q == prot_pkg::PH_DATA && busy_q == prot_pkg::BUSY_IDLE
     && op_q == `OP_WRITE_PW && cnt_q == 7'h40 && wel_q) |=> pw_q == $past(sh_q))
    else $error("password not stored");

  // Unlock outcome split by password match
  sequence s_unlock_good;
    s_unlock_end ##0 (sh_q == pw_q);
  endsequence

  sequence s_unlock_bad;
    s_unlock_end ##0 (sh_q != pw_q);
  endsequence

  AST_GOOD_START: assert property (@(posedge clk) disable iff (!rstn)
    s_unlock_good |=> busy_q == prot_pkg::BUSY_GOOD)
    else $error("correct password did not start unlock wait");
  AST_BAD_START: assert property (@(posedge clk) disable iff (!rstn)
    s_unlock_bad |=> busy_q == prot_pkg::BUSY_BAD)
    else $error("wrong password not sent to long wait");
  AST_GOOD_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    (busy_q == prot_pkg::BUSY_GOOD && tmr_q < 16'(GOOD_CYC - 1))
      |=> busy_q == prot_pkg::BUSY_GOOD)
    else $error("unlock wait ended early");
  AST_BAD_END: assert property (@(posedge clk) disable iff (!rstn)
    (busy_q == prot_pkg::BUSY_BAD && tmr_q == 16'(BAD_CYC - 1))
      |=> !op_in_progress_flag)
    else $error("busy not cleared after wrong password wait");
  AST_READ_SHIFT: assert property (@(posedge clk) disable iff (!rstn)
    (ph_q == prot_pkg::PH_DATA && op_q == `OP_READ_PW && ev.fall && cnt_q != 7'h40)
      |=> miso == $past(rd_q[63]) && miso_oe)
    else $error("password read bit out of order");
  AST_OE_OFF: assert property (@(posedge clk) disable iff (!rstn)
    ev.cs_end |=> !miso_oe)
    else $error("output still driven after chip select rise");
  AST_PW_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !(ev.cs_end && op_q == `OP_WRITE_PW) |=> $stable(pw_q))
    else $error("password changed outside a write");
  AST_DPB_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !(ev.cs_end && op_q == `OP_GLOBAL_UNLOCK) |=> $stable(dpb_q))
    else $error("dynamic bits changed outside global unlock");
  AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    lock_q |=> lock_q)
    else $error("lock flag dropped without reset");
  AST_SPB_TAKEN: assert property (@(posedge clk) disable iff (!rstn)
    (solid_wr_req && lock_q && busy_q == prot_pkg::BUSY_IDLE)
      |=> spb_q == $past(solid_wr_val))
    else $error("solid bits not taken while unlocked");
endmodule
`default_nettype wire

// file: verification/spi_host_model.sv
// Serial host model that frames opcodes and data towards the flash block.
// Assumes the bench clock paces it; serial clock is 16 clk cycles per bit.
`include "prot_map.svh"
`default_nettype none
module spi_host_model (
  // Clock
  input  wire logic clk,
  // Serial link
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_bit;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    last_bit = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One frame: opcode then nbits of data, MSB first, sampled on rising sclk
  task automatic frame(input logic [7:0] op, input int nbits, input logic [63:0] wd,
                       output logic [63:0] rd);
    logic [71:0] sh;
    sh = {op, wd};
    rd = 64'h0000_0000_0000_0000;
    cs_n <= 1'b0;
    ticks(8);
    for (int i = 0; i < 8 + nbits; i++) begin
      sclk <= 1'b0;
      mosi <= sh[71 - i];
      ticks(8);
      sclk <= 1'b1;
      if (i >= 8) begin
        // Released line reads as the inverse of the previous bit read
        last_bit = miso_oe ? miso : ~last_bit;
        rd = {rd[62:0], last_bit};
      end
      ticks(8);
    end
    sclk <= 1'b0;
    ticks(8);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    ticks(8);
  endtask

  // Write enable sent ahead of a guarded command
  task automatic wren();
    logic [63:0] rd;
    frame(`OP_WREN, 0, 64'h0000_0000_0000_0000, rd);
  endtask
endmodule
`default_nettype wire

// file: verification/flash_prot_cmd_tb.sv
// Self-checking bench for the protection command block.
// Assumes spi_host_model drives the serial pins; 200 MHz clock.
`include "prot_map.svh"
`default_nettype none
module flash_prot_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk;
  logic                     rstn;
  logic                     solid_wr_req;
  logic [`SECTOR_COUNT-1:0] solid_wr_val;
  logic [`SECTOR_COUNT-1:0] dyn_bits;
  logic [`SECTOR_COUNT-1:0] solid_bits;
  logic [`SECTOR_COUNT-1:0] unprot;
  logic                     sclk;
  logic                     cs_n;
  logic                     mosi;
  logic                     miso;
  logic                     miso_oe;
  logic                     latch;
  logic                     busy;
  logic                     lock;
  logic [63:0]              pw;
  logic [63:0]              rd;
  int                       n_errors;
  int                       total_checks;
  int                       cycles;
  int                       n;

  flash_prot_cmd i_dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .solid_wr_req(solid_wr_req), .solid_wr_val(solid_wr_val),
    .dynamic_protect_bit(dyn_bits), .solid_protect_bit(solid_bits),
    .sector_unprotected(unprot), .write_latch_flag(latch), .op_in_progress_flag(busy),
    .solid_bits_lock_flag(lock), .protection_password(pw));
  spi_host_model i_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Counts cycles until the busy flag drops
  task automatic busy_len(output int len);
    len = 0;
    while (busy === 1'b1 && len < 30000) begin
      @(posedge clk);
      len++;
    end
  endtask

  task automatic t_reset();
    check("lock_rst", lock, 1'b0);
    check("busy_rst", busy, 1'b0);
    check("dyn_rst", &dyn_bits, 1'b1);
    check("unprot_rst", |unprot, 1'b0);
    check("pw_rst", pw, `PW_RESET);
    check("oe_rst", miso_oe, 1'b0);
  endtask

  task automatic t_global();
    i_host.frame(`OP_GLOBAL_UNLOCK, 0, 64'h0000_0000_0000_0000, rd);
    check("dyn_no_latch", &dyn_bits, 1'b1);
    i_host.wren();
    check("latch_set", latch, 1'b1);
    i_host.frame(`OP_GLOBAL_UNLOCK, 0, 64'h0000_0000_0000_0000, rd);
    check("dyn_clear", |dyn_bits, 1'b0);
    check("unprot_all", &unprot, 1'b1);
    check("latch_used", latch, 1'b0);
  endtask

  task automatic t_password();
    i_host.frame(`OP_READ_PW, 64, 64'h0000_0000_0000_0000, rd);
    check("pw_read_rst", rd, `PW_RESET);
    i_host.frame(`OP_WRITE_PW, 64, 64'h0123_4567_89ab_cdef, rd);
    check("pw_no_latch", pw, `PW_RESET);
    i_host.wren();
    i_host.frame(`OP_WRITE_PW, 64, 64'h0123_4567_89ab_cdef, rd);
    check("pw_stored", pw, 64'h0123_4567_89ab_cdef);
    i_host.frame(`OP_READ_PW, 64, 64'h0000_0000_0000_0000, rd);
    check("pw_read", rd, 64'h0123_4567_89ab_cdef);
    check("oe_off", miso_oe, 1'b0);
  endtask

  task automatic t_bad_unlock();
    solid_wr_req <= 1'b1;
    solid_wr_val <= '1;
    repeat (4) @(posedge clk);
    check("solid_refused", |solid_bits, 1'b0);
    solid_wr_req <= 1'b0;
    i_host.frame(`OP_PW_UNLOCK, 64, 64'h0000_0000_0000_0000, rd);
    check("busy_no_latch", busy, 1'b0);
    i_host.wren();
    i_host.frame(`OP_PW_UNLOCK, 64, 64'h0000_0000_0000_0000, rd);
    check("busy_bad", busy, 1'b1);
    busy_len(n);
    check("bad_len", n >= 16000 && n <= 24000, 1'b1);
    check("lock_bad", lock, 1'b0);
  endtask

  task automatic t_good_unlock();
    i_host.wren();
    i_host.frame(`OP_PW_UNLOCK, 64, 64'h0123_4567_89ab_cdef, rd);
    check("busy_good", busy, 1'b1);
    busy_len(n);
    check("good_len", n < 1000, 1'b1);
    check("lock_good", lock, 1'b1);
    i_host.ticks(`GOOD_PW_CYCLES);
    solid_wr_req <= 1'b1;
    solid_wr_val <= {256{2'b01}};
    repeat (4) @(posedge clk);
    check("solid_taken", solid_bits === {256{2'b01}}, 1'b1);
    check("unprot_mix", unprot === {256{2'b10}}, 1'b1);
    solid_wr_req <= 1'b0;
  endtask

  // Reset in mid-run after the lock flag was set
  task automatic t_mid_reset();
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    check("lock_mid_rst", lock, 1'b0);
    check("dyn_mid_rst", &dyn_bits, 1'b1);
    check("solid_mid_rst", |solid_bits, 1'b0);
    check("pw_mid_rst", pw, `PW_RESET);
    solid_wr_req <= 1'b1;
    solid_wr_val <= '1;
    repeat (4) @(posedge clk);
    check("solid_mid_refused", |solid_bits, 1'b0);
    solid_wr_req <= 1'b0;
  endtask

  initial begin
    rstn = 1'b0;
    solid_wr_req = 1'b0;
    solid_wr_val = '0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_global();
    t_password();
    t_bad_unlock();
    t_good_unlock();
    t_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
